/* tx_drive_select.sv */
// tx_drive_select.sv
// picks the field set in force for one lane and registers it for the driver.
// assumes mode inputs are synchronous and already decoded by the parent.
`timescale 1ns/10ps
module tx_drive_select
  import tx_level_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire lane_fields_s fields_i,
  input  wire drive_mode_e  mode_i,
  input  wire logic         rate2_i,
  output drive_setting_s    drive_o
);

  drive_setting_s next_drive;  // combinational choice

  //////////////////////////////////////////////////////////////////////////////
  // field choice by mode
  always_comb begin
    next_drive = '0;
    case (mode_i)
      MODE_FULL_MILD: begin
        next_drive.active    = 1'b1;
        next_drive.deemph_en = 1'b1;
        next_drive.level     = fields_i.level_full_mild_rate2;
        next_drive.fine      = fields_i.fine_deemph_full_mild_rate2;
      end
      MODE_FULL_STRONG: begin
        next_drive.active    = 1'b1;
        next_drive.deemph_en = 1'b1;
        next_drive.level     = fields_i.level_full_strong_rate2;
        next_drive.fine      = fields_i.fine_deemph_full_strong_rate2;
      end
      // rate1 low level, rate2 low level
      MODE_LOW_SWING: begin
        next_drive.active = 1'b1;
        next_drive.deemph_en = 1'b0;
        next_drive.fine      = '0;
        next_drive.level     = rate2_i
                             ? {1'b0, fields_i.level_low_swing_rate2}
                             : {1'b0, fields_i.level_low_swing_rate1};
      end
      // full swing at first rate is set by the lower half, not here
      MODE_OTHER: begin
        next_drive = '0;
      end
      default: begin
        next_drive = '0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered so the driver sees a glitch-free word
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      drive_o <= '0;
    end else begin
      drive_o <= next_drive;
    end
  end

endmodule

/* tx_lane_level_ctl.sv */
// tx_lane_level_ctl.sv
// register bank for per-lane transmit level and fine de-emphasis settings,
// with the lane select, swing mode and de-emphasis strength controls beside it.
// assumes a plain register port (one-cycle strobes, read data one cycle later),
// synchronous inputs, and a separate hot reset that must not clear sticky fields.
`timescale 1ns/10ps
module tx_lane_level_ctl
  import tx_level_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,     // fundamental reset, active low
  input  wire logic              hot_reset_i,  // non-fundamental reset, active high
  input  wire logic [ADDR_W-1:0] addr_i,       // byte address
  input  wire logic [DATA_W-1:0] wdata_i,      // write data
  input  wire logic              wr_i,         // write strobe
  input  wire logic              rd_i,         // read strobe
  input  wire logic              rate2_i,      // link runs at second rate
  output logic [DATA_W-1:0]      rdata_o,      // read data, cycle after rd_i
  output drive_setting_s         drive_o [NUM_LANES]  // setting in force per lane
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [NUM_LANES-1:0]  lane_select;          // lanes a level write reaches
  logic                  low_swing_enable;     // port swing mode
  logic                  deemph_strength_select; // 1 is mild, 0 is strong
  logic [DATA_W-1:0]     rdata;                // read data flop
  logic [DATA_W-1:0]     next_rdata;           // read mux result
  drive_mode_e           mode;                 // field set in force
  lane_fields_s          wr_fields;            // decoded write word
  lane_fields_s          lane_fields [NUM_LANES]; // stored settings per lane
  logic [NUM_LANES-1:0]  lane_wr;              // per-lane write enables
  logic [LANE_IDX_W-1:0] read_lane;            // lane shown on a read
  logic                  sel_any;              // at least one lane selected
  logic                  wr_level;             // write to level register
  logic                  wr_serdes_ctl;        // write to lane select register
  logic                  wr_serdes_cfg;        // write to swing mode register
  logic                  wr_link_ctl2;         // write to de-emphasis register

  //////////////////////////////////////////////////////////////////////////////
  // helper: index of the lowest set bit, zero when none is set
  function automatic logic [LANE_IDX_W-1:0] lowest_lane(input logic [NUM_LANES-1:0] m);
    logic [LANE_IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_LANES - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = LANE_IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // helper: address match for a write
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off);
    return wr && (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // write decode; unmapped addresses are simply dropped
  always_comb begin
    wr_level      = wr_hit(wr_i, addr_i, OFF_TX_LEVEL_CTL);
    wr_serdes_ctl = wr_hit(wr_i, addr_i, OFF_SERDES_CTL);
    wr_serdes_cfg = wr_hit(wr_i, addr_i, OFF_SERDES_CFG);
    wr_link_ctl2  = wr_hit(wr_i, addr_i, OFF_LINK_CTL2);
  end

  // the write word splits into fields once, every lane sees the same value
  assign wr_fields = unpack_fields(wdata_i);

  //////////////////////////////////////////////////////////////////////////////
  // lane select register
  // a hot reset returns it to all lanes; the level fields themselves stay put
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lane_select <= RST_LANE_SEL;
    end else if (hot_reset_i) begin
      lane_select <= RST_LANE_SEL;
    end else if (wr_serdes_ctl) begin
      lane_select <= wdata_i[LANE_SEL_LSB +: NUM_LANES];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // swing mode register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      low_swing_enable <= RST_LOW_SWING;
    end else if (hot_reset_i) begin
      low_swing_enable <= RST_LOW_SWING;
    end else if (wr_serdes_cfg) begin
      low_swing_enable <= wdata_i[LOW_SWING_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // de-emphasis strength register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      deemph_strength_select <= RST_DEEMPH_SEL;
    end else if (hot_reset_i) begin
      deemph_strength_select <= RST_DEEMPH_SEL;
    end else if (wr_link_ctl2) begin
      deemph_strength_select <= wdata_i[DEEMPH_SEL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode decode shared by all lanes
  // low swing when enable bit set
  assign mode = mode_of(low_swing_enable, rate2_i, deemph_strength_select);

  //////////////////////////////////////////////////////////////////////////////
  // per-lane storage and driver selection
  generate
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      assign lane_wr[g] = wr_level && lane_select[g];

      tx_lane_store u_store (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .wr_en_i     (lane_wr[g]),
        .wr_fields_i (wr_fields),
        .fields_o    (lane_fields[g])
      );

      // fine codes dropped in low swing
      tx_drive_select u_select (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .fields_i (lane_fields[g]),
        .mode_i   (mode),
        .rate2_i  (rate2_i),
        .drive_o  (drive_o[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read lane choice
  // lowest selected lane
  always_comb begin
    sel_any   = |lane_select;
    read_lane = lowest_lane(lane_select);
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped or no-strobe reads give zero
  always_comb begin
    next_rdata = ZERO_WORD;
    if (rd_i) begin
      case (addr_i)
        // level word; an empty lane select has no lane to show
        OFF_TX_LEVEL_CTL: begin
          if (sel_any) begin
            next_rdata = pack_fields(lane_fields[read_lane]);
          end
        end
        // lane select
        OFF_SERDES_CTL: begin
          next_rdata[LANE_SEL_LSB +: NUM_LANES] = lane_select;
        end
        // swing mode
        OFF_SERDES_CFG: begin
          next_rdata[LOW_SWING_BIT] = low_swing_enable;
        end
        // de-emphasis strength
        OFF_LINK_CTL2: begin
          next_rdata[DEEMPH_SEL_BIT] = deemph_strength_select;
        end
        // field set in force right now
        OFF_DRIVE_STAT: begin
          next_rdata[$bits(drive_mode_e)-1:0] = mode;
        end
        default: begin
          next_rdata = ZERO_WORD;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data register; holds only for the cycle after the strobe,
  // zero otherwise so a stale word can never be mistaken for an answer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata <= ZERO_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;

endmodule

/* tx_lane_level_ctl_properties.sv */
// tx_lane_level_ctl_properties.sv
// port-level checks of the transmit level register bank.
// assumes it is bound to tx_lane_level_ctl and sees only that module's ports.
`timescale 1ns/10ps
module tx_lane_level_ctl_properties
  import tx_level_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic              hot_reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic              rate2_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire drive_setting_s    drive_o [NUM_LANES]
);
  //////////////////////////////////////////////////////////////////////////////
  logic [1:0] since_rst;  // edges since reset release, saturates at 3

  // drive outputs load their defaults on the first edge after release, so hold off
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      since_rst <= 2'h0;
    end else if (since_rst != 2'h3) begin
      since_rst <= since_rst + 2'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////////////////////////////////
  // no write, no hot reset and a steady rate: nothing may move the drive
  sequence s_quiet;
    since_rst == 2'h3 && !wr_i && !hot_reset_i && $stable(rate2_i);
  endsequence
  sequence s_wr_level;
    wr_i && addr_i == OFF_TX_LEVEL_CTL;
  endsequence
  sequence s_rd_level;
    rd_i && addr_i == OFF_TX_LEVEL_CTL;
  endsequence

  property p_idle_zero;
    !$past(rd_i) |-> rdata_o == ZERO_WORD;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");

  property p_low_byte;
    $past(rd_i) && $past(addr_i) == OFF_TX_LEVEL_CTL |-> rdata_o[7:0] == 8'h00;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("level word low byte not zero");

  // a read after a write returns the written fields, or zero with no lane chosen
  property p_wr_rd;
    s_wr_level ##1 (!wr_i && !hot_reset_i) ##1 s_rd_level
      |=> rdata_o == ZERO_WORD || rdata_o == ($past(wdata_i, 3) & 32'hFFFF_FF00);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("level readback differs from write");

  property p_stat_bits;
    $past(rd_i) && $past(addr_i) == OFF_DRIVE_STAT |-> rdata_o[DATA_W-1:2] == '0;
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("mode word upper bits set");

  property p_unmapped;
    $past(rd_i) && $past(addr_i) == 8'h20 |-> rdata_o == ZERO_WORD;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_rst_out;
    $rose(resetn_i) |-> rdata_o == ZERO_WORD && drive_o[0] == '0;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");

  // without de-emphasis the fine code is off and only 4-bit levels apply
  property p_ls_lane0;
    drive_o[0].active && !drive_o[0].deemph_en
      |-> drive_o[0].fine == '0 && !drive_o[0].level[4];
  endproperty
  a_ls_lane0: assert property (p_ls_lane0) else $error("fine code active in low swing");

  property p_inactive;
    !drive_o[1].active |-> drive_o[1] == '0;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive lane drives a setting");

  property p_quiet;
    s_quiet ##1 s_quiet |=> $stable(drive_o[1]);
  endproperty
  a_quiet: assert property (p_quiet) else $error("drive changed without a cause");
endmodule

bind tx_lane_level_ctl tx_lane_level_ctl_properties tx_lane_level_ctl_properties_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .hot_reset_i(hot_reset_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rate2_i(rate2_i), .rdata_o(rdata_o),
  .drive_o(drive_o));

/* tx_lane_level_ctl_tb.sv */
// tx_lane_level_ctl_tb.sv
// self-checking bench for the transmit level register bank.
// assumes the plain register port with one-cycle strobes and registered reads.
`timescale 1ns/10ps
module tx_lane_level_ctl_tb;
  import tx_level_pkg::*;
  logic              clk_i;
  logic              resetn_i;
  logic              hot_reset_i;
  logic              wr_i;
  logic              rd_i;
  logic              rate2_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic [DATA_W-1:0] rdata_o;
  drive_setting_s    drive_o [NUM_LANES];
  int                fails;
  int                samples_checked;
  int                cycles = 0;
  localparam logic [DATA_W-1:0] DEF_WORD = 32'h8953_9700;  // every field at default
  localparam logic [DATA_W-1:0] NEW_WORD = 32'hA5CB_7D00;  // distinct value per field

  tx_lane_level_ctl tx_lane_level_ctl_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .hot_reset_i(hot_reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rate2_i(rate2_i), .rdata_o(rdata_o),
    .drive_o(drive_o));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_drv(input int lane, input drive_setting_s exp);
    chk(DATA_W'(drive_o[lane]), DATA_W'(exp));
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, looked at there
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  // drive outputs settle two edges after a write, one edge after a rate change
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic set_rate(input logic r);
    @(posedge clk_i);
    rate2_i <= r;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    samples_checked = 0;
    resetn_i = 1'b0;
    hot_reset_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    rate2_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    // defaults, then full swing at the first rate leaves lanes idle
    rd_reg(OFF_TX_LEVEL_CTL, DEF_WORD);
    rd_reg(OFF_SERDES_CTL, 32'h0000_000F);
    settle();
    chk_drv(0, '0);
    // second rate, strong de-emphasis from reset
    set_rate(1'b1);
    settle();
    for (int i = 0; i < NUM_LANES; i++)
      chk_drv(i, {1'b1, 1'b1, 5'h13, 3'h2});
    // write only lane 1, other lanes keep their values
    wr_reg(OFF_SERDES_CTL, 32'h0000_0002);
    wr_reg(OFF_TX_LEVEL_CTL, NEW_WORD);
    rd_reg(OFF_TX_LEVEL_CTL, NEW_WORD);
    settle();
    chk_drv(1, {1'b1, 1'b1, 5'h0B, 3'h6});
    chk_drv(0, {1'b1, 1'b1, 5'h13, 3'h2});
    wr_reg(OFF_SERDES_CTL, 32'h0000_0001);
    rd_reg(OFF_TX_LEVEL_CTL, DEF_WORD);
    wr_reg(OFF_SERDES_CTL, 32'h0000_0003);
    rd_reg(OFF_TX_LEVEL_CTL, DEF_WORD);
    // no lane chosen: reads zero and writes land nowhere
    wr_reg(OFF_SERDES_CTL, 32'h0000_0000);
    wr_reg(OFF_TX_LEVEL_CTL, 32'hFFFF_FF00);
    rd_reg(OFF_TX_LEVEL_CTL, 32'h0000_0000);
    wr_reg(OFF_SERDES_CTL, 32'h0000_0002);
    rd_reg(OFF_TX_LEVEL_CTL, NEW_WORD);
    // mild de-emphasis selects the other full-swing pair
    wr_reg(OFF_LINK_CTL2, 32'h0000_0040);
    rd_reg(OFF_DRIVE_STAT, 32'h0000_0001);
    settle();
    chk_drv(1, {1'b1, 1'b1, 5'h1D, 3'h3});
    chk_drv(0, {1'b1, 1'b1, 5'h17, 3'h4});
    // low swing wins and turns de-emphasis off at both rates
    wr_reg(OFF_SERDES_CFG, 32'h0000_0001);
    rd_reg(OFF_DRIVE_STAT, 32'h0000_0003);
    settle();
    chk_drv(1, {1'b1, 1'b0, 5'h0A, 3'h0});
    set_rate(1'b0);
    settle();
    chk_drv(1, {1'b1, 1'b0, 5'h05, 3'h0});
    chk_drv(0, {1'b1, 1'b0, 5'h09, 3'h0});
    // unmapped and read-only places ignore writes
    wr_reg(8'h20, 32'hFFFF_FFFF);
    wr_reg(OFF_DRIVE_STAT, 32'h0000_0000);
    rd_reg(8'h20, 32'h0000_0000);
    rd_reg(OFF_DRIVE_STAT, 32'h0000_0003);
    // hot reset restores the control defaults but not the stored levels
    @(posedge clk_i);
    hot_reset_i <= 1'b1;
    @(posedge clk_i);
    hot_reset_i <= 1'b0;
    set_rate(1'b1);
    settle();
    chk_drv(1, {1'b1, 1'b1, 5'h0B, 3'h6});
    rd_reg(OFF_SERDES_CTL, 32'h0000_000F);
    wr_reg(OFF_SERDES_CTL, 32'h0000_0002);
    rd_reg(OFF_TX_LEVEL_CTL, NEW_WORD);
    // fundamental reset in mid-run restores every default
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    wr_reg(OFF_SERDES_CTL, 32'h0000_0002);
    rd_reg(OFF_TX_LEVEL_CTL, DEF_WORD);
    finish_test();
  end
endmodule

/* tx_lane_store.sv */
// tx_lane_store.sv
// software-sticky storage of the level fields for one lane.
// assumes the parent decodes the write and gates it with this lane's select bit.
`timescale 1ns/10ps
module tx_lane_store
  import tx_level_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         resetn_i,   // fundamental reset only
  input  wire logic         wr_en_i,    // write aimed at this lane
  input  wire lane_fields_s wr_fields_i,
  output lane_fields_s      fields_o
);

  lane_fields_s fields;  // stored settings

  //////////////////////////////////////////////////////////////////////////////
  // sticky storage: hot reset never reaches here, so settings survive it
  // fundamental reset only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fields <= RST_FIELDS;
    end else if (wr_en_i) begin
      fields <= wr_fields_i;
    end
  end

  assign fields_o = fields;

endmodule

/* tx_level_pkg.sv */
// tx_level_pkg.sv
// shared constants, field layouts and types for the per-lane transmit level block.
// assumes one 200 MHz clock and a plain register port with 8-bit byte addresses.
package tx_level_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus and lane geometry
  localparam int ADDR_W     = 8;   // byte address width of the register port
  localparam int DATA_W     = 32;  // register data width
  localparam int NUM_LANES  = 4;   // lanes behind one serdes, one per select bit
  localparam int LANE_IDX_W = $clog2(NUM_LANES);

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TX_LEVEL_CTL = 8'h00; // per-lane level settings
  localparam logic [ADDR_W-1:0] OFF_SERDES_CTL   = 8'h04; // lane_select lives here
  localparam logic [ADDR_W-1:0] OFF_SERDES_CFG   = 8'h08; // low_swing_enable lives here
  localparam logic [ADDR_W-1:0] OFF_LINK_CTL2    = 8'h0C; // deemph_strength_select here
  localparam logic [ADDR_W-1:0] OFF_DRIVE_STAT   = 8'h10; // read-only active mode

  //////////////////////////////////////////////////////////////////////////////
  // field positions inside the level control word (bits 7:0 read as zero)
  localparam int LEVEL_MILD_LSB   = 8;   // 12:8
  localparam int FINE_MILD_LSB    = 13;  // 15:13
  localparam int LEVEL_STRONG_LSB = 16;  // 20:16
  localparam int FINE_STRONG_LSB  = 21;  // 23:21
  localparam int LEVEL_LOW1_LSB   = 24;  // 27:24
  localparam int LEVEL_LOW2_LSB   = 28;  // 31:28
  localparam int LEVEL_FULL_W     = 5;
  localparam int FINE_W           = 3;
  localparam int LEVEL_LOW_W      = 4;

  // field reset values, restored only by the fundamental reset
  localparam logic [LEVEL_FULL_W-1:0] RST_LEVEL_MILD   = 5'h17;
  localparam logic [FINE_W-1:0]       RST_FINE_MILD    = 3'h4;
  localparam logic [LEVEL_FULL_W-1:0] RST_LEVEL_STRONG = 5'h13;
  localparam logic [FINE_W-1:0]       RST_FINE_STRONG  = 3'h2;
  localparam logic [LEVEL_LOW_W-1:0]  RST_LEVEL_LOW1   = 4'h9;
  localparam logic [LEVEL_LOW_W-1:0]  RST_LEVEL_LOW2   = 4'h8;

  // control bits in the companion registers
  localparam int                     LANE_SEL_LSB    = 0;     // lane_select[3:0]
  localparam logic [NUM_LANES-1:0]   RST_LANE_SEL    = 4'hF;  // all lanes after reset
  localparam int                     LOW_SWING_BIT   = 0;
  localparam logic                   RST_LOW_SWING   = 1'h0;
  localparam logic                   LOW_SWING_ON    = 1'h1;
  localparam int                     DEEMPH_SEL_BIT  = 6;
  localparam logic                   DEEMPH_MILD     = 1'h1;  // -3.5dB, 0 is -6.0dB
  localparam logic                   RST_DEEMPH_SEL  = 1'h0;
  localparam logic [DATA_W-1:0]      ZERO_WORD       = 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [LEVEL_LOW_W-1:0]  level_low_swing_rate2;
    logic [LEVEL_LOW_W-1:0]  level_low_swing_rate1;
    logic [FINE_W-1:0]       fine_deemph_full_strong_rate2;
    logic [LEVEL_FULL_W-1:0] level_full_strong_rate2;
    logic [FINE_W-1:0]       fine_deemph_full_mild_rate2;
    logic [LEVEL_FULL_W-1:0] level_full_mild_rate2;
  } lane_fields_s;

  typedef struct packed {
    logic                    active;     // this register governs the lane now
    logic                    deemph_en;  // de-emphasis applied
    logic [LEVEL_FULL_W-1:0] level;      // driver voltage level
    logic [FINE_W-1:0]       fine;       // fine de-emphasis code
  } drive_setting_s;

  typedef enum logic [1:0] {
    MODE_OTHER       = 2'b00,  // full swing at first rate, governed elsewhere
    MODE_FULL_MILD   = 2'b01,
    MODE_FULL_STRONG = 2'b10,
    MODE_LOW_SWING   = 2'b11
  } drive_mode_e;

  localparam lane_fields_s RST_FIELDS = '{
    level_low_swing_rate2:         RST_LEVEL_LOW2,
    level_low_swing_rate1:         RST_LEVEL_LOW1,
    fine_deemph_full_strong_rate2: RST_FINE_STRONG,
    level_full_strong_rate2:       RST_LEVEL_STRONG,
    fine_deemph_full_mild_rate2:   RST_FINE_MILD,
    level_full_mild_rate2:         RST_LEVEL_MILD
  };

  //////////////////////////////////////////////////////////////////////////////
  // field word to stored fields
  function automatic lane_fields_s unpack_fields(input logic [DATA_W-1:0] w);
    lane_fields_s f;
    f.level_low_swing_rate2         = w[LEVEL_LOW2_LSB +: LEVEL_LOW_W];
    f.level_low_swing_rate1         = w[LEVEL_LOW1_LSB +: LEVEL_LOW_W];
    f.fine_deemph_full_strong_rate2 = w[FINE_STRONG_LSB +: FINE_W];
    f.level_full_strong_rate2       = w[LEVEL_STRONG_LSB +: LEVEL_FULL_W];
    f.fine_deemph_full_mild_rate2   = w[FINE_MILD_LSB +: FINE_W];
    f.level_full_mild_rate2         = w[LEVEL_MILD_LSB +: LEVEL_FULL_W];
    return f;
  endfunction

  // stored fields to read word, unused low bits zero
  function automatic logic [DATA_W-1:0] pack_fields(input lane_fields_s f);
    logic [DATA_W-1:0] w;
    w = ZERO_WORD;
    w[LEVEL_LOW2_LSB +: LEVEL_LOW_W]    = f.level_low_swing_rate2;
    w[LEVEL_LOW1_LSB +: LEVEL_LOW_W]    = f.level_low_swing_rate1;
    w[FINE_STRONG_LSB +: FINE_W]        = f.fine_deemph_full_strong_rate2;
    w[LEVEL_STRONG_LSB +: LEVEL_FULL_W] = f.level_full_strong_rate2;
    w[FINE_MILD_LSB +: FINE_W]          = f.fine_deemph_full_mild_rate2;
    w[LEVEL_MILD_LSB +: LEVEL_FULL_W]   = f.level_full_mild_rate2;
    return w;
  endfunction

  // which field set governs the driver, low swing dominates
  function automatic drive_mode_e mode_of(input logic low_swing, input logic rate2,
                                          input logic deemph_sel);
    if (low_swing == LOW_SWING_ON) return MODE_LOW_SWING;
    else if (!rate2)               return MODE_OTHER;
    else if (deemph_sel == DEEMPH_MILD) return MODE_FULL_MILD;
    else                           return MODE_FULL_STRONG;
  endfunction

endpackage
